// >>> hw/pot_control_pkg.sv
// Shared constants and types for the potentiometer pin control block
package pot_control_pkg;

  // ----------------------------------------------------------------
  // Clock and timing
  // ----------------------------------------------------------------
  localparam int CLOCK_PERIOD_NS  = 8;
  localparam int STORE_TIME_US    = 15000;
  localparam int STORE_CYCLES_DFL = STORE_TIME_US * 1000 / CLOCK_PERIOD_NS;
  localparam int LOCK_W           = 21;

  // ----------------------------------------------------------------
  // Word layout and channel count
  // ----------------------------------------------------------------
  localparam int WORD_W     = 16;
  localparam int CHANNELS   = 4;
  localparam int CNT_W      = 8;
  localparam int MIN_EDGES  = 16;
  localparam int I2C_BITS   = 8;

  typedef struct packed {
    logic [3:0] ctrl;
    logic [3:0] addr;
    logic [7:0] data;
  } cmd_word_t;

  // ----------------------------------------------------------------
  // Command codes
  // ----------------------------------------------------------------
  localparam logic [3:0] CMD_WR_WIPER  = 4'h1;
  localparam logic [3:0] CMD_PRELOAD   = 4'h2;
  localparam logic [3:0] CMD_RELOAD    = 4'h7;
  localparam logic [3:0] CMD_STORE     = 4'h9;
  localparam logic [3:0] CMD_WR_EEPROM = 4'hb;

  // ----------------------------------------------------------------
  // Reset values and address straps
  // ----------------------------------------------------------------
  localparam logic [7:0] EEPROM_RESET  = 8'h80;
  localparam logic [4:0] I2C_ADDR_BASE = 5'h0a;

  // Pin vector bit positions after synchronising
  localparam int P_SEL  = 7;
  localparam int P_SCL  = 6;
  localparam int P_SDA  = 5;
  localparam int P_A0   = 4;
  localparam int P_A1   = 3;
  localparam int P_WPN  = 2;
  localparam int P_LDN  = 1;
  localparam int P_RSTN = 0;
  localparam logic [7:0] PINS_IDLE = 8'h7f;

  typedef enum logic [2:0] {I2C_IDLE, I2C_ADDR, I2C_ACKA, I2C_BYTE, I2C_ACKD,
                            I2C_SKIP} i2c_state_t;

endpackage

// >>> hw/pot_control_pins.sv
// Pin level control of a quad digital potentiometer: SPI or I2C, strobes, protect
`timescale 1ns/100ps
// What this block does
// - Interface select low picks SPI and high picks I2C; the master keeps it defined.
// - Serial data is captured on the falling edge of the shared serial clock in both modes.
// - The data pin is the two-way I2C data line in I2C mode and only an input in SPI mode.
// - In I2C mode the two address pins give the low device address bits.
// - In SPI mode the second address pin is an open-drain data output that only pulls low.
// - In SPI mode the first address pin is an active-low frame select whose rise ends a frame.
// - Write protect blocks every wiper and EEPROM change except reloading EEPROM into wipers.
// - Write protect is active low, and an unused input is held high by the master.
// - The load strobe copies each preloaded input register into its wiper register at once.
// - The load strobe acts on its falling edge only; a high level moves nothing.
// - The active-low hardware reset refreshes all wiper registers from EEPROM.
// - The serial word is 16 bits, MSB first: four control, four address, eight data bits.
// - An SPI frame whose falling clock count is not a multiple of eight is ignored.
// - During an EEPROM store of about 15 ms the device ignores and does not acknowledge commands.
module pot_control_pins
  import pot_control_pkg::*;
#(
  parameter int STORE_CYCLES = STORE_CYCLES_DFL
) (
  input  wire logic                     clock,
  input  wire logic                     rst,
  input  wire logic                     interface_select,
  input  wire logic                     serial_clock,
  input  wire logic                     data_in,
  output      logic                     data_out,
  output      logic                     data_oe,
  input  wire logic                     device_address_bit0,
  input  wire logic                     device_address_bit1,
  output      logic                     sdo_out,
  output      logic                     sdo_oe,
  input  wire logic                     write_protect_n,
  input  wire logic                     load_wiper_strobe_n,
  input  wire logic                     reset_n,
  output      logic [CHANNELS-1:0][7:0] wiper_position_register,
  output      logic                     store_busy
);

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [7:0] pins_meta_r;
  logic [7:0] pins_sync_r;
  logic [7:0] pins_prev_r;

  always_ff @(posedge clock) begin
    if (rst) begin
      pins_meta_r <= PINS_IDLE;
      pins_sync_r <= PINS_IDLE;
      pins_prev_r <= PINS_IDLE;
    end else begin
      pins_meta_r <= {interface_select, serial_clock, data_in, device_address_bit0,
                      device_address_bit1, write_protect_n, load_wiper_strobe_n,
                      reset_n};
      pins_sync_r <= pins_meta_r;
      pins_prev_r <= pins_sync_r;
    end
  end

  logic i2c_mode;
  logic scl_fall;
  logic scl_rise;
  logic sda_s;
  logic frame_sel;
  logic frame_end;
  logic wp_act;
  logic load_fall;
  logic hw_reset;

  assign i2c_mode  = pins_sync_r[P_SEL];
  assign scl_fall  = pins_prev_r[P_SCL] & ~pins_sync_r[P_SCL];
  assign scl_rise  = ~pins_prev_r[P_SCL] & pins_sync_r[P_SCL];
  assign sda_s     = pins_sync_r[P_SDA];
  assign frame_sel = ~i2c_mode & ~pins_sync_r[P_A0];
  assign frame_end = ~i2c_mode & ~pins_prev_r[P_A0] & pins_sync_r[P_A0];
  assign wp_act    = ~pins_sync_r[P_WPN];
  assign load_fall = pins_prev_r[P_LDN] & ~pins_sync_r[P_LDN];
  assign hw_reset  = ~pins_sync_r[P_RSTN];

  // Count is valid only as a whole number of bytes covering a full word
  function automatic logic count_ok(input logic [CNT_W-1:0] cnt);
    count_ok = (cnt[2:0] == 3'h0) && (cnt >= CNT_W'(MIN_EDGES));
  endfunction

  // ----------------------------------------------------------------
  // SPI receiver
  // ----------------------------------------------------------------
  logic [WORD_W-1:0] spi_shift_r;
  logic [CNT_W-1:0]  spi_count_r;
  logic              sdo_bit_r;
  logic              spi_done;
  logic              busy_r;

  always_ff @(posedge clock) begin
    if (rst) begin
      spi_shift_r <= '0;
      spi_count_r <= '0;
    end else if (frame_sel && scl_fall) begin
      spi_shift_r <= {spi_shift_r[WORD_W-2:0], sda_s};
      if (spi_count_r != '1) begin
        spi_count_r <= spi_count_r + CNT_W'(1);
      end
    end else if (!frame_sel) begin
      spi_count_r <= '0;
    end
  end

  // Daisy-chain bit leaves on the rising edge so the next part samples it on the fall
  always_ff @(posedge clock) begin
    if (rst) begin
      sdo_bit_r <= 1'b1;
    end else if (!frame_sel) begin
      sdo_bit_r <= 1'b1;
    end else if (scl_rise) begin
      sdo_bit_r <= spi_shift_r[WORD_W-1];
    end
  end

  assign spi_done = frame_end && count_ok(spi_count_r) && !busy_r;
  assign sdo_out  = 1'b0;
  assign sdo_oe   = frame_sel && !sdo_bit_r;

  // ----------------------------------------------------------------
  // I2C receiver, write transfers only
  // ----------------------------------------------------------------
  i2c_state_t        i2c_st_r;
  logic [7:0]        i2c_byte_r;
  logic [3:0]        i2c_bits_r;
  logic              i2c_second_r;
  logic [7:0]        i2c_hi_r;
  logic              i2c_ack_r;
  logic              i2c_done;
  logic              i2c_start;
  logic              i2c_stop;
  logic [6:0]        own_addr;
  logic [7:0]        next_byte;

  assign i2c_start = i2c_mode && pins_sync_r[P_SCL] && pins_prev_r[P_SDA] && !sda_s;
  assign i2c_stop  = i2c_mode && pins_sync_r[P_SCL] && !pins_prev_r[P_SDA] && sda_s;
  assign own_addr  = {I2C_ADDR_BASE, pins_sync_r[P_A1], pins_sync_r[P_A0]};
  assign next_byte = {i2c_byte_r[6:0], sda_s};

  always_ff @(posedge clock) begin
    if (rst || !i2c_mode) begin
      i2c_st_r     <= I2C_IDLE;
      i2c_byte_r   <= '0;
      i2c_bits_r   <= '0;
      i2c_second_r <= 1'b0;
      i2c_hi_r     <= '0;
    end else if (i2c_start) begin
      i2c_st_r   <= I2C_ADDR;
      // The clock fall that closes a start carries no bit; the count wraps to zero on it
      i2c_bits_r <= '1;
    end else if (i2c_stop) begin
      i2c_st_r <= I2C_IDLE;
    end else if (scl_fall) begin
      case (i2c_st_r)
        I2C_ADDR, I2C_BYTE: begin
          i2c_byte_r <= next_byte;
          i2c_bits_r <= i2c_bits_r + 4'h1;
          if (i2c_bits_r == 4'(I2C_BITS - 1)) begin
            i2c_bits_r <= '0;
            if (i2c_st_r == I2C_BYTE) begin
              i2c_st_r <= busy_r ? I2C_SKIP : I2C_ACKD;
            end else if (next_byte == {own_addr, 1'b0} && !busy_r) begin
              i2c_st_r     <= I2C_ACKA;
              i2c_second_r <= 1'b0;
            end else begin
              i2c_st_r <= I2C_SKIP;
            end
          end
        end
        I2C_ACKA: begin
          i2c_st_r <= I2C_BYTE;
        end
        I2C_ACKD: begin
          i2c_st_r     <= I2C_BYTE;
          i2c_second_r <= !i2c_second_r;
          i2c_hi_r     <= i2c_byte_r;
        end
        default: begin
          i2c_st_r <= i2c_st_r;
        end
      endcase
    end
  end

  // Acknowledge is pulled low from the eighth fall to the ninth fall
  always_ff @(posedge clock) begin
    if (rst) begin
      i2c_ack_r <= 1'b0;
    end else begin
      i2c_ack_r <= i2c_mode && (i2c_st_r == I2C_ACKA || i2c_st_r == I2C_ACKD);
    end
  end

  assign i2c_done = i2c_mode && scl_fall && (i2c_st_r == I2C_ACKD) && i2c_second_r;
  assign data_out = 1'b0;
  assign data_oe  = i2c_ack_r && i2c_mode;

  // ----------------------------------------------------------------
  // Command decode and wiper storage
  // ----------------------------------------------------------------
  cmd_word_t                word;
  logic                     exec_go;
  logic [1:0]               chan;
  logic [CHANNELS-1:0][7:0] input_r;
  logic [CHANNELS-1:0][7:0] eeprom_r;
  logic [CHANNELS-1:0][7:0] wiper_r;
  logic [CHANNELS-1:0]      pending_r;
  logic [LOCK_W-1:0]        lock_r;
  logic                     store_go;
  logic                     reload_go;

  assign word      = i2c_mode ? cmd_word_t'({i2c_hi_r, i2c_byte_r}) : cmd_word_t'(spi_shift_r);
  assign exec_go   = (spi_done || i2c_done) && !busy_r;
  assign chan      = word.addr[1:0];
  assign store_go  = exec_go && !wp_act && word.ctrl == CMD_STORE;
  assign reload_go = exec_go && word.ctrl == CMD_RELOAD;

  always_ff @(posedge clock) begin
    if (rst) begin
      wiper_r   <= {CHANNELS{EEPROM_RESET}};
      input_r   <= {CHANNELS{EEPROM_RESET}};
      pending_r <= '0;
    end else if (hw_reset || reload_go) begin
      wiper_r   <= eeprom_r;
      pending_r <= '0;
    end else begin
      if (load_fall && !wp_act) begin
        for (int i = 0; i < CHANNELS; i++) begin
          if (pending_r[i]) begin
            wiper_r[i] <= input_r[i];
          end
        end
        pending_r <= '0;
      end
      if (exec_go && word.ctrl == CMD_WR_WIPER && !wp_act) begin
        wiper_r[chan] <= word.data;
      end
      if (exec_go && word.ctrl == CMD_PRELOAD) begin
        input_r[chan]   <= word.data;
        pending_r[chan] <= 1'b1;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      eeprom_r <= {CHANNELS{EEPROM_RESET}};
    end else if (store_go) begin
      eeprom_r[chan] <= wiper_r[chan];
    end else if (exec_go && word.ctrl == CMD_WR_EEPROM && !wp_act) begin
      eeprom_r[chan] <= word.data;
    end
  end

  // Store lock; a long count, kept as a parameter so a bench can shorten it
  always_ff @(posedge clock) begin
    if (rst) begin
      lock_r <= '0;
      busy_r <= 1'b0;
    end else if (store_go) begin
      lock_r <= LOCK_W'(STORE_CYCLES - 1);
      busy_r <= 1'b1;
    end else if (lock_r != '0) begin
      lock_r <= lock_r - LOCK_W'(1);
    end else begin
      busy_r <= 1'b0;
    end
  end

  assign wiper_position_register = wiper_r;
  assign store_busy              = busy_r;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sequence frame_closes;
    frame_end ##0 count_ok(spi_count_r);
  endsequence

  sequence ack_slot;
    (i2c_st_r == I2C_ACKA) ##0 scl_fall;
  endsequence

  frame_accept_a: assert property (@(posedge clock) disable iff (rst)
    spi_done |-> frame_closes) else $error("SPI word taken outside a valid frame end");

  bad_count_a: assert property (@(posedge clock) disable iff (rst)
    (frame_end && spi_count_r[2:0] != 3'h0) |-> !spi_done)
    else $error("SPI frame with partial byte was accepted");

  wp_hold_a: assert property (@(posedge clock) disable iff (rst)
    (wp_act && !hw_reset && !reload_go) |=> $stable(wiper_r))
    else $error("Wiper changed while write protect active");

  hw_refresh_a: assert property (@(posedge clock) disable iff (rst)
    hw_reset |=> wiper_r == $past(eeprom_r))
    else $error("Hardware reset did not refresh wipers");

  strobe_copy_a: assert property (@(posedge clock) disable iff (rst)
    (load_fall && !wp_act && !hw_reset && !exec_go && pending_r[0])
      |=> wiper_r[0] == $past(input_r[0]) && pending_r == '0)
    else $error("Load strobe did not copy preloaded value");

  strobe_level_a: assert property (@(posedge clock) disable iff (rst)
    (pins_sync_r[P_LDN] && pins_prev_r[P_LDN] && !exec_go && !hw_reset) |=> $stable(wiper_r))
    else $error("Wiper moved with load strobe held high");

  store_lock_a: assert property (@(posedge clock) disable iff (rst)
    store_go |=> busy_r [*8] ##0 !exec_go)
    else $error("Store lock did not hold");

  ack_order_a: assert property (@(posedge clock) disable iff (rst)
    ack_slot |=> (i2c_st_r == I2C_BYTE) ##1 !data_oe)
    else $error("I2C acknowledge not released after ninth clock");

  pin_roles_a: assert property (@(posedge clock) disable iff (rst)
    (sdo_oe |-> !i2c_mode && frame_sel) and (data_oe |-> i2c_mode))
    else $error("Pin driven in the wrong interface mode");

  sample_fall_a: assert property (@(posedge clock) disable iff (rst)
    ($changed(spi_shift_r) && !$past(rst)) |-> $past(scl_fall))
    else $error("SPI shift moved without a falling clock edge");

endmodule // pot_control_pins

// >>> tb/pot_bus_master.sv
// Bus master model that writes words over the shared SPI and I2C pins
`timescale 1ns/100ps
module pot_bus_master
  import pot_control_pkg::*;
(
  input  wire logic clock,
  input  wire logic sda_line,
  input  wire logic sdo_line,
  output logic      sclk,
  output logic      sda_drv,
  output logic      frame_n
);
  // ----
  // Link timing: 10 system clocks per hold gives 80 ns, a 160 ns SPI clock period and 240 ns per I2C bit
  // ----
  localparam int HALF = 10;
  // Pulled-up output line, one sample per falling clock
  logic [23:0] sdo_seen;
  initial begin
    sclk     = 1'b0;
    sda_drv  = 1'b1;
    frame_n  = 1'b1;
    sdo_seen = '0;
  end
  task automatic hold();
    repeat (HALF) @(negedge clock);
  endtask
  // Last n bits of w, MSB first; clock stands low between frames
  task automatic spi(input logic [23:0] w, input int n);
    frame_n = 1'b0;
    hold();
    for (int i = n - 1; i >= 0; i--) begin
      sclk    = 1'b1;
      sda_drv = w[i];
      hold();
      sdo_seen = {sdo_seen[22:0], sdo_line};
      sclk     = 1'b0;
      hold();
    end
    frame_n = 1'b1;
    sda_drv = ~sda_drv;
    hold();
  endtask
  task automatic i2c_bit(input logic b, output logic seen);
    sda_drv = b;
    hold();
    sclk = 1'b1;
    hold();
    seen = sda_line;
    sclk = 1'b0;
    hold();
  endtask
  // Address byte then one 16-bit word, high byte first; counts acknowledges
  task automatic i2c(input logic [7:0] adr, input logic [15:0] w, output int acks);
    logic        s;
    logic [23:0] all;
    all     = {adr, w};
    acks    = 0;
    sclk    = 1'b1;
    sda_drv = 1'b1;
    hold();
    sda_drv = 1'b0;
    hold();
    sclk = 1'b0;
    hold();
    for (int i = 23; i >= 0; i--) begin
      i2c_bit(all[i], s);
      if (i % 8 == 0) begin
        i2c_bit(1'b1, s); // Released so the device can pull low
        acks += (s === 1'b0) ? 1 : 0;
      end
    end
    sda_drv = 1'b0;
    hold();
    sclk = 1'b1;
    hold();
    sda_drv = 1'b1;
    hold();
  endtask
endmodule // pot_bus_master

// >>> tb/pot_control_pins_tb.sv
// Self-checking bench for the potentiometer pin control block
`timescale 1ns/100ps
module pot_control_pins_tb;
  import pot_control_pkg::*;
  logic                     clock = 0, rst = 1, sel = 0, wp_n = 1, ld_n = 1, hrst_n = 1;
  logic                     a0 = 0, a1 = 1, sclk, sda_drv, frame_n;
  logic                     data_out, data_oe, sdo_out, sdo_oe, busy;
  logic [CHANNELS-1:0][7:0] wipers;
  logic [7:0]               exp_w [CHANNELS];
  logic [7:0]               eep [CHANNELS];
  int                       num_errors = 0, cmp_count = 0, acks;
  wire                      sda_line = sda_drv & ~data_oe;
  wire                      a0_pin = sel ? a0 : frame_n;
  wire                      a1_pin = sel ? a1 : ~sdo_oe;
  always #4 clock = ~clock;
  pot_control_pins #(.STORE_CYCLES(1000)) dut (.clock(clock), .rst(rst),
    .interface_select(sel), .serial_clock(sclk), .data_in(sda_line), .data_out(data_out),
    .data_oe(data_oe), .device_address_bit0(a0_pin), .device_address_bit1(a1_pin),
    .sdo_out(sdo_out), .sdo_oe(sdo_oe), .write_protect_n(wp_n),
    .load_wiper_strobe_n(ld_n), .reset_n(hrst_n), .wiper_position_register(wipers),
    .store_busy(busy));
  pot_bus_master master (.clock(clock), .sda_line(sda_line), .sdo_line(a1_pin), .sclk(sclk),
    .sda_drv(sda_drv), .frame_n(frame_n));
  // ----
  // Expectation helpers and checks
  // ----
  function automatic logic [15:0] mk(logic [3:0] c, int ch, logic [7:0] d);
    cmd_word_t w;
    w = '{ctrl: c, addr: 4'(ch), data: d};
    return w;
  endfunction
  task automatic chk(input logic [7:0] got, input logic [7:0] ev, input string what);
    cmp_count++;
    if (got !== ev) begin
      num_errors++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, ev);
    end
  endtask
  task automatic chk_all(input string what);
    repeat (8) @(negedge clock);
    for (int c = 0; c < CHANNELS; c++) chk(wipers[c], exp_w[c], what);
    chk({6'h00, sdo_out, data_out}, 8'h00, "open drain levels");
  endtask
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic wait_idle();
    for (int i = 0; i < 3000 && busy !== 1'b0; i++) @(negedge clock);
    if (busy !== 1'b0) begin
      num_errors++;
      $display("wrong value at %0t: store lock never ended", $time);
      tally_and_finish();
    end
  endtask
  // ----
  // Main sequence
  // ----
  initial begin
    logic [7:0]  d;
    logic [15:0] prev;
    void'($urandom(19));
    repeat (20) @(negedge clock);
    rst = 0;
    repeat (8) @(negedge clock);
    foreach (exp_w[c]) begin
      exp_w[c] = EEPROM_RESET;
      eep[c]   = EEPROM_RESET;
    end
    chk_all("reset values");
    foreach (exp_w[c]) begin
      exp_w[c] = 8'($urandom);
      master.spi({8'h00, mk(CMD_WR_WIPER, c, exp_w[c])}, 16);
      chk({7'h00, sdo_oe}, 8'h00, "sdo released");
    end
    chk_all("spi writes");
    // The word left in the shift register comes back out on the open-drain line, MSB first
    prev = mk(CMD_WR_WIPER, 3, exp_w[3]);
    exp_w[1] = 8'($urandom);
    master.spi({8'($urandom), mk(CMD_WR_WIPER, 1, exp_w[1])}, 24);
    chk(master.sdo_seen[23:16], prev[15:8], "sdo high byte");
    chk(master.sdo_seen[15:8], prev[7:0], "sdo low byte");
    chk_all("24 edge frame");
    master.spi({8'h00, mk(CMD_WR_WIPER, 2, 8'h5a)}, 15);
    master.spi({8'h01, mk(CMD_WR_WIPER, 2, 8'ha5)}, 17);
    chk_all("bad edge counts");
    d = 8'($urandom);
    master.spi({8'h00, mk(CMD_PRELOAD, 0, d)}, 16);
    master.spi({8'h00, mk(CMD_PRELOAD, 2, ~d)}, 16);
    repeat (40) @(negedge clock);
    chk_all("preload held");
    ld_n = 0;
    exp_w[0] = d;
    exp_w[2] = ~d;
    chk_all("strobe copy");
    ld_n = 1;
    wp_n = 0;
    master.spi({8'h00, mk(CMD_WR_WIPER, 1, ~exp_w[1])}, 16);
    master.spi({8'h00, mk(CMD_PRELOAD, 3, ~exp_w[3])}, 16);
    master.spi({8'h00, mk(CMD_WR_EEPROM, 1, 8'h11)}, 16);
    ld_n = 0;
    chk_all("protected writes");
    ld_n = 1;
    master.spi({8'h00, mk(CMD_RELOAD, 1, 8'h00)}, 16);
    // Reload refreshes every channel from its stored copy, not only the addressed one
    foreach (exp_w[c]) exp_w[c] = eep[c];
    chk_all("reload under protect");
    wp_n = 1;
    exp_w[3] = 8'($urandom);
    master.spi({8'h00, mk(CMD_WR_WIPER, 3, exp_w[3])}, 16);
    master.spi({8'h00, mk(CMD_STORE, 3, 8'h00)}, 16);
    eep[3] = exp_w[3];
    chk({7'h00, busy}, 8'h01, "store lock");
    master.spi({8'h00, mk(CMD_WR_WIPER, 3, ~exp_w[3])}, 16);
    chk_all("command while locked");
    wait_idle();
    eep[0] = 8'($urandom);
    master.spi({8'h00, mk(CMD_WR_EEPROM, 0, eep[0])}, 16);
    wait_idle();
    exp_w[3] = 8'($urandom);
    master.spi({8'h00, mk(CMD_WR_WIPER, 3, exp_w[3])}, 16);
    chk_all("write after lock");
    hrst_n = 0;
    repeat (10) @(negedge clock);
    hrst_n = 1;
    foreach (exp_w[c]) exp_w[c] = eep[c];
    chk_all("hardware reset");
    sel = 1;
    a0  = 1'($urandom);
    a1  = 1'($urandom);
    repeat (8) @(negedge clock);
    exp_w[2] = 8'($urandom);
    master.i2c({I2C_ADDR_BASE, a1, a0, 1'b0}, mk(CMD_WR_WIPER, 2, exp_w[2]), acks);
    chk(8'(acks), 8'h03, "i2c acks");
    chk_all("i2c write");
    master.i2c({I2C_ADDR_BASE, a1, ~a0, 1'b0}, mk(CMD_WR_WIPER, 2, 8'h33), acks);
    chk(8'(acks), 8'h00, "wrong address acks");
    chk_all("wrong address");
    tally_and_finish();
  end
endmodule // pot_control_pins_tb
